//--- src/lsm_exec.sv
/*
 Execution unit for stores with pointer update, word load, multiply,
 threaded next, no-op, OR, and system and user stack pops and push.
 Assumes the decode path presents fetched operand values with start,
 and the register file and memories accept one write per port per cycle.
*/
// How it works
// - Pre-decrement store: pointer minus one, then write
// - Data store reaches full 64K data space
// - Pre-increment store: pointer plus one, then write
// - Even pair means program, odd means data
// - Word load copies 16-bit source to pair
// - Lower-addressed source byte goes to even register
// - Multiply even dst byte by source, unsigned
// - Product written back to the destination pair
// - Multiply flags: C over 255, Z, S, V clear
// - Next loads PC from word at IP, IP plus two
// - No-op changes nothing, takes four cycles
// - OR result stored in destination, source kept
// - OR flags: Z, S from bit 7, V clear
// - Pop reads at stack pointer, then increments it
// - Stack pointer high at D8, low at D9
// - Decrementing user pop: copy, pointer minus one
// - Incrementing user pop: copy, pointer plus one
// - User pops only touch the register file
// - Push decrements stack pointer, then writes source
// - Transfers, loads, next, no-op, stacks keep flags
`timescale 1ns/10ps
`default_nettype none
module lsm_exec
    import lsm_pkg::*;
#(
    parameter int TIMER_WIDTH = 5
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic start,
    input wire lsm_instr_t instr,
    input wire logic [15:0] prog_word,
    input wire logic [7:0] stack_read_data,
    output logic busy,
    output logic done,
    output logic illegal,
    output lsm_reg_wr_t reg_wr_a,
    output lsm_reg_wr_t reg_wr_b,
    output lsm_mem_wr_t mem_wr,
    output logic [15:0] stack_pointer,
    output logic [15:0] instruction_pointer,
    output logic [15:0] program_counter,
    output lsm_flags_t flags
);
    initial begin
        if (TIMER_WIDTH < 5) begin
            $error("lsm_exec: TIMER_WIDTH too small");
        end
    end

    lsm_state_t state;
    lsm_state_t next_state;
    logic timer_done;

    // Opcode decode
    wire logic [7:0] op = instr.opcode;
    wire logic is_predec = (op == OP_STORE_PREDEC);
    wire logic is_preinc = (op == OP_STORE_PREINC);
    wire logic is_word = (op == OP_WORD_RR) || (op == OP_WORD_IR) || (op == OP_WORD_IML);
    wire logic is_mul = (op == OP_MUL_R) || (op == OP_MUL_IR) || (op == OP_MUL_IM);
    wire logic is_next = (op == OP_NEXT);
    wire logic is_nop = (op == OP_NOP);
    wire logic is_or = (op >= OP_OR_LO) && (op <= OP_OR_HI);
    wire logic is_pop = (op == OP_POP_R) || (op == OP_POP_IR);
    wire logic is_upop_dec = (op == OP_UPOP_DEC);
    wire logic is_upop_inc = (op == OP_UPOP_INC);
    wire logic is_push = (op == OP_PUSH_R);
    wire logic is_known = is_predec || is_preinc || is_word || is_mul || is_next
        || is_nop || is_or || is_pop || is_upop_dec || is_upop_inc || is_push;
    wire logic accept = start && (state == LSM_IDLE);

    // Execution time per instruction
    wire logic [4:0] or_cycles = (op == OP_OR_LO) ? CYC_OR : CYC_OR_LONG;
    wire logic [4:0] cycles = (is_predec || is_preinc) ? CYC_STORE
        : is_word ? CYC_WORD
        : is_mul ? CYC_MUL
        : is_next ? CYC_NEXT
        : is_or ? or_cycles
        : (is_pop || is_upop_dec || is_upop_inc || is_push) ? CYC_STACK
        : CYC_NOP;

    // Store address path
    wire logic [15:0] pair_dec = instr.pair_val - 16'h0001;
    wire logic [15:0] pair_inc = instr.pair_val + 16'h0001;
    wire logic [15:0] store_addr = is_predec ? pair_dec : pair_inc;
    wire logic store_to_data = instr.pair_addr[0];

    // Multiply and OR
    wire logic [15:0] product = 16'(instr.dst_val) * 16'(instr.src_val);
    wire logic [7:0] or_result = instr.dst_val | instr.src_val;

    // Stack pointer arithmetic
    wire logic [15:0] sp_inc = stack_pointer + 16'h0001;
    wire logic [15:0] sp_dec = stack_pointer - 16'h0001;
    wire logic [7:0] user_sp_dec = instr.dst_val - 8'h01;
    wire logic [7:0] user_sp_inc = instr.dst_val + 8'h01;

    // Register writes of the accepted instruction
    lsm_reg_wr_t next_wr_a;
    lsm_reg_wr_t next_wr_b;
    lsm_mem_wr_t next_mem;
    lsm_flags_t next_flags;
    logic [15:0] next_sp;
    logic [15:0] next_ip;
    logic [15:0] next_pc;

    always_comb begin
        next_wr_a = '0;
        next_wr_b = '0;
        next_mem = '0;
        next_flags = flags;
        next_sp = stack_pointer;
        next_ip = instruction_pointer;
        next_pc = program_counter;
        if (accept) begin
            if (is_predec || is_preinc) begin
                // Full 16-bit address, so all 64K of data space is reachable
                next_mem = '{we: 1'b1, to_data: store_to_data, addr: store_addr,
                    data: instr.src_val};
                next_wr_a = '{we: 1'b1, addr: {instr.pair_addr[7:1], 1'b0},
                    data: store_addr[15:8]};
                next_wr_b = '{we: 1'b1, addr: {instr.pair_addr[7:1], 1'b1},
                    data: store_addr[7:0]};
            end else if (is_word) begin
                next_wr_a = '{we: 1'b1, addr: {instr.dst_addr[7:1], 1'b0},
                    data: instr.src_word[15:8]};
                next_wr_b = '{we: 1'b1, addr: {instr.dst_addr[7:1], 1'b1},
                    data: instr.src_word[7:0]};
            end else if (is_mul) begin
                next_wr_a = '{we: 1'b1, addr: {instr.dst_addr[7:1], 1'b0},
                    data: product[15:8]};
                next_wr_b = '{we: 1'b1, addr: {instr.dst_addr[7:1], 1'b1},
                    data: product[7:0]};
                next_flags.c = (product > 16'(MUL_CARRY_LIMIT));
                next_flags.z = (product == 16'h0000);
                next_flags.s = product[15];
                next_flags.v = 1'b0;
            end else if (is_next) begin
                next_pc = prog_word;
                next_ip = instruction_pointer + IP_STEP;
            end else if (is_or) begin
                next_wr_a = '{we: 1'b1, addr: instr.dst_addr, data: or_result};
                next_flags.z = (or_result == 8'h00);
                next_flags.s = or_result[7];
                next_flags.v = 1'b0;
            end else if (is_pop) begin
                next_wr_a = '{we: 1'b1, addr: instr.dst_addr, data: stack_read_data};
                next_sp = sp_inc;
            end else if (is_upop_dec || is_upop_inc) begin
                // Source value comes from the register file only
                next_wr_a = '{we: 1'b1, addr: instr.src_val, data: instr.src_word[7:0]};
                next_wr_b = '{we: 1'b1, addr: instr.dst_addr,
                    data: is_upop_dec ? user_sp_dec : user_sp_inc};
            end else if (is_push) begin
                next_sp = sp_dec;
                // System stack lives in data memory, where pops read it back
                next_mem = '{we: 1'b1, to_data: 1'b1, addr: sp_dec,
                    data: instr.src_val};
            end
            // No-op falls through with nothing changed
        end
    end

    // Pop and push also mirror the pointer bytes into the register file
    wire logic sp_moved = accept && (is_pop || is_push);

    always_comb begin
        next_state = state;
        unique case (state)
            LSM_IDLE: begin
                if (accept && is_known) begin
                    next_state = LSM_EXEC;
                end
            end
            LSM_EXEC: begin
                next_state = LSM_WAIT;
            end
            LSM_WAIT: begin
                if (timer_done) begin
                    next_state = LSM_IDLE;
                end
            end
            default: begin
                next_state = LSM_IDLE;
            end
        endcase
    end

    lsm_cycle_timer #(
        .WIDTH(TIMER_WIDTH)
    ) u_timer (
        .clock(clock),
        .nrst(nrst),
        .load(accept && is_known),
        .cycles(TIMER_WIDTH'(cycles)),
        .done(timer_done)
    );

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= LSM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Pointer bytes reach D8 and D9 one cycle after the pointer update
    logic sp_mirror;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sp_mirror <= 1'b0;
        end else begin
            sp_mirror <= sp_moved;
        end
    end

    lsm_reg_wr_t sp_wr_high;
    lsm_reg_wr_t sp_wr_low;
    assign sp_wr_high = '{we: sp_mirror, addr: ADDR_STACK_POINTER_HIGH,
        data: stack_pointer[15:8]};
    assign sp_wr_low = '{we: sp_mirror, addr: ADDR_STACK_POINTER_LOW,
        data: stack_pointer[7:0]};

    // Lanes are free then, since no instruction is accepted while busy
    wire lsm_reg_wr_t lane_a = sp_mirror ? sp_wr_high : next_wr_a;
    wire lsm_reg_wr_t lane_b = sp_mirror ? sp_wr_low : next_wr_b;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_wr_a <= '0;
            reg_wr_b <= '0;
            mem_wr <= '0;
            flags <= '0;
            stack_pointer <= SP_RESET;
            instruction_pointer <= IP_RESET;
            program_counter <= PC_RESET;
        end else begin
            reg_wr_a <= lane_a;
            reg_wr_b <= lane_b;
            mem_wr <= next_mem;
            flags <= next_flags;
            stack_pointer <= next_sp;
            instruction_pointer <= next_ip;
            program_counter <= next_pc;
        end
    end

    assign busy = (state != LSM_IDLE);
    assign done = (state == LSM_WAIT) && timer_done;
    assign illegal = accept && !is_known;
endmodule
`default_nettype wire

//--- src/lsm_pkg.sv
/*
 Shared constants and types of the instruction execution block.
 Assumes the fetch path presents one decoded instruction at a time.
*/
package lsm_pkg;
    localparam logic [7:0] OP_STORE_PREDEC = 8'hF2;
    localparam logic [7:0] OP_STORE_PREINC = 8'hF3;
    localparam logic [7:0] OP_WORD_RR = 8'hC4;
    localparam logic [7:0] OP_WORD_IR = 8'hC5;
    localparam logic [7:0] OP_WORD_IML = 8'hC6;
    localparam logic [7:0] OP_MUL_R = 8'h84;
    localparam logic [7:0] OP_MUL_IR = 8'h85;
    localparam logic [7:0] OP_MUL_IM = 8'h86;
    localparam logic [7:0] OP_NEXT = 8'h0F;
    localparam logic [7:0] OP_NOP = 8'hFF;
    localparam logic [7:0] OP_OR_LO = 8'h42;
    localparam logic [7:0] OP_OR_HI = 8'h46;
    localparam logic [7:0] OP_POP_R = 8'h50;
    localparam logic [7:0] OP_POP_IR = 8'h51;
    localparam logic [7:0] OP_UPOP_DEC = 8'h92;
    localparam logic [7:0] OP_UPOP_INC = 8'h93;
    localparam logic [7:0] OP_PUSH_R = 8'h70;
    localparam logic [7:0] ADDR_STACK_POINTER_HIGH = 8'hD8;
    localparam logic [7:0] ADDR_STACK_POINTER_LOW = 8'hD9;
    localparam logic [7:0] MUL_CARRY_LIMIT = 8'hFF;
    localparam logic [15:0] IP_STEP = 16'h0002;
    localparam logic [4:0] CYC_STORE = 5'h0E;
    localparam logic [4:0] CYC_WORD = 5'h08;
    localparam logic [4:0] CYC_MUL = 5'h16;
    localparam logic [4:0] CYC_NEXT = 5'h0A;
    localparam logic [4:0] CYC_NOP = 5'h04;
    localparam logic [4:0] CYC_OR = 5'h04;
    localparam logic [4:0] CYC_OR_LONG = 5'h06;
    localparam logic [4:0] CYC_STACK = 5'h08;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] IP_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Flag bits: carry, zero, sign, overflow, decimal-adjust, half-carry
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } lsm_flags_t;

    // One decoded instruction with its operand values already fetched
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] dst_addr;
        logic [7:0] dst_val;
        logic [7:0] src_val;
        logic [15:0] src_word;
        logic [15:0] pair_val;
        logic [7:0] pair_addr;
    } lsm_instr_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } lsm_reg_wr_t;

    typedef struct packed {
        logic we;
        logic to_data;
        logic [15:0] addr;
        logic [7:0] data;
    } lsm_mem_wr_t;

    typedef enum logic [1:0] {
        LSM_IDLE = 2'b00,
        LSM_EXEC = 2'b01,
        LSM_WAIT = 2'b10
    } lsm_state_t;
endpackage

//--- src/lsm_cycle_timer.sv
/*
 Down counter that holds an instruction for its execution time.
 Assumes load is a single-cycle pulse while the counter is idle.
*/
`timescale 1ns/10ps
`default_nettype none
module lsm_cycle_timer
    import lsm_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic load,
    input wire logic [WIDTH-1:0] cycles,
    output logic done
);
    initial begin
        if (WIDTH < 5) begin
            $error("lsm_cycle_timer: WIDTH too small for longest instruction");
        end
    end

    logic [WIDTH-1:0] count;
    wire logic [WIDTH-1:0] next_count = load ? cycles - WIDTH'(1)
        : (count != '0 ? count - WIDTH'(1) : count);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Done at a count of one, so the load cycle plus the remaining count make the execution time
    assign done = (count == WIDTH'(1));
endmodule
`default_nettype wire

//--- tb/lsm_exec_monitor.sv
/*
 Port checker of the execution unit.
 Assumes it is bound to lsm_exec and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module lsm_exec_monitor
    import lsm_pkg::*;
#(
    parameter int TIMER_WIDTH = 5
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic start,
    input wire lsm_instr_t instr,
    input wire logic [15:0] prog_word,
    input wire logic [7:0] stack_read_data,
    input wire logic busy,
    input wire logic done,
    input wire logic illegal,
    input wire lsm_reg_wr_t reg_wr_a,
    input wire lsm_reg_wr_t reg_wr_b,
    input wire lsm_mem_wr_t mem_wr,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] instruction_pointer,
    input wire logic [15:0] program_counter,
    input wire lsm_flags_t flags
);
    wire [7:0] op = instr.opcode;
    // Unknown opcodes raise illegal at once, so this is a taken request
    wire take = start && !busy && !illegal;
    wire is_mul = op == OP_MUL_R || op == OP_MUL_IR || op == OP_MUL_IM;
    wire is_or = op >= OP_OR_LO && op <= OP_OR_HI;
    wire is_st = op == OP_STORE_PREDEC || op == OP_STORE_PREINC;
    wire [15:0] prod = instr.dst_val * instr.src_val;
    wire [7:0] orv = instr.dst_val | instr.src_val;
    wire [15:0] st_addr = (op == OP_STORE_PREINC) ? instr.pair_val + 16'h0001
                                                  : instr.pair_val - 16'h0001;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_nop_len;
        take && op == OP_NOP |=> !done ##1 !done ##1 done ##1 !busy;
    endproperty
    a_nop_len: assert property (p_nop_len) else $error("nop length wrong");
    property p_store_len;
        take && is_st |-> ##13 done;
    endproperty
    a_store_len: assert property (p_store_len) else $error("store length wrong");
    property p_store_addr;
        take && is_st |=> mem_wr.we && mem_wr.addr == $past(st_addr)
            && mem_wr.to_data == $past(instr.pair_addr[0]) && mem_wr.data == $past(instr.src_val);
    endproperty
    a_store_addr: assert property (p_store_addr) else $error("store write wrong");
    property p_mul_flags;
        take && is_mul |=> flags == {$past(prod) > 16'h00FF, $past(prod) == 16'h0000,
            $past(prod[15]), 1'b0, $past(flags.d), $past(flags.h)};
    endproperty
    a_mul_flags: assert property (p_mul_flags) else $error("multiply flags wrong");
    property p_or_flags;
        take && is_or |=> flags == {$past(flags.c), $past(orv) == 8'h00, $past(orv[7]),
            1'b0, $past(flags.d), $past(flags.h)};
    endproperty
    a_or_flags: assert property (p_or_flags) else $error("or flags wrong");
    property p_keep_flags;
        take && !is_mul && !is_or |=> $stable(flags);
    endproperty
    a_keep_flags: assert property (p_keep_flags) else $error("flags changed");
    property p_next;
        take && op == OP_NEXT |=> program_counter == $past(prog_word)
            && instruction_pointer == $past(instruction_pointer) + 16'h0002;
    endproperty
    a_next: assert property (p_next) else $error("next update wrong");
    property p_pop_sp;
        take && (op == OP_POP_R || op == OP_POP_IR) |=> stack_pointer == $past(stack_pointer) + 16'h0001;
    endproperty
    a_pop_sp: assert property (p_pop_sp) else $error("pop pointer wrong");
    property p_push_sp;
        take && op == OP_PUSH_R |=> stack_pointer == $past(stack_pointer) - 16'h0001;
    endproperty
    a_push_sp: assert property (p_push_sp) else $error("push pointer wrong");
    property p_upop_nomem;
        take && (op == OP_UPOP_DEC || op == OP_UPOP_INC) |=> !mem_wr.we [*8];
    endproperty
    a_upop_nomem: assert property (p_upop_nomem) else $error("user pop hit memory");
    property p_sp_mirror;
        take && (op == OP_POP_R || op == OP_POP_IR || op == OP_PUSH_R) |=> ##1 reg_wr_a.we
            && reg_wr_a.addr == ADDR_STACK_POINTER_HIGH && reg_wr_a.data == stack_pointer[15:8]
            && reg_wr_b.we && reg_wr_b.addr == ADDR_STACK_POINTER_LOW
            && reg_wr_b.data == stack_pointer[7:0];
    endproperty
    a_sp_mirror: assert property (p_sp_mirror) else $error("stack pointer mirror wrong");
    c_stack: cover property (take && (op == OP_PUSH_R || op == OP_POP_R));
    c_mul: cover property (take && is_mul);
    c_store: cover property (take && is_st);
    c_or: cover property (take && is_or);
endmodule
bind lsm_exec lsm_exec_monitor #(.TIMER_WIDTH(TIMER_WIDTH)) u_mon (.clock(clock), .nrst(nrst),
    .start(start), .instr(instr), .prog_word(prog_word), .stack_read_data(stack_read_data),
    .busy(busy), .done(done), .illegal(illegal), .reg_wr_a(reg_wr_a), .reg_wr_b(reg_wr_b),
    .mem_wr(mem_wr), .stack_pointer(stack_pointer), .instruction_pointer(instruction_pointer),
    .program_counter(program_counter), .flags(flags));
`default_nettype wire

//--- tb/lsm_mem_model.sv
/*
 Program and external data memory beside the execution unit.
 Byte wide, a word has its high byte at the lower address.
*/
`timescale 1ns/10ps
`default_nettype none
module lsm_mem_model
    import lsm_pkg::*;
(
    input wire logic clock,
    input wire logic [15:0] instruction_pointer,
    input wire logic [15:0] stack_pointer,
    input wire lsm_mem_wr_t mem_wr,
    output logic [15:0] prog_word,
    output logic [7:0] stack_read_data
);
    logic [7:0] prog [65536];
    logic [7:0] data [65536];
    // Filled so that no read ever returns an unknown
    initial begin
        for (int i = 0; i < 65536; i++) begin
            prog[i] = 8'(i) ^ 8'h5A;
            data[i] = 8'(i) ^ 8'hA5;
        end
    end
    assign prog_word = {prog[instruction_pointer], prog[instruction_pointer + 16'h0001]};
    assign stack_read_data = data[stack_pointer];
    always @(posedge clock) begin
        if (mem_wr.we) begin
            if (mem_wr.to_data) begin
                data[mem_wr.addr] <= mem_wr.data;
            end else begin
                prog[mem_wr.addr] <= mem_wr.data;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
/*
 Self-checking bench of the execution unit with its memory model.
 Assumes the checker is bound through its own file.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
    import lsm_pkg::*;
;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    lsm_instr_t instr = '0;
    logic [15:0] prog_word, sp, ip, pc;
    logic [7:0] stack_read_data;
    logic busy, done, illegal;
    lsm_reg_wr_t wa, wb, ra, rb;
    lsm_mem_wr_t wm, mw;
    lsm_flags_t fl, pf;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #4 clock = ~clock;
    lsm_exec #(.TIMER_WIDTH(5)) DUT (.clock(clock), .nrst(nrst), .start(start), .instr(instr),
        .prog_word(prog_word), .stack_read_data(stack_read_data), .busy(busy), .done(done),
        .illegal(illegal), .reg_wr_a(wa), .reg_wr_b(wb), .mem_wr(wm), .stack_pointer(sp),
        .instruction_pointer(ip), .program_counter(pc), .flags(fl));
    lsm_mem_model mem (.clock(clock), .instruction_pointer(ip), .stack_pointer(sp),
        .mem_wr(wm), .prog_word(prog_word), .stack_read_data(stack_read_data));
    task automatic end_of_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Issues one instruction, keeps its first-cycle writes, times it to done
    task automatic go(input lsm_instr_t i, input int n);
        int k;
        pf = fl;
        @(posedge clock);
        start <= 1'b1;
        instr <= i;
        @(posedge clock);
        start <= 1'b0;
        #1;
        ra = wa;
        rb = wb;
        mw = wm;
        k = 1;
        while (done !== 1'b1 && k < 40) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk("cycles", 16'(n - 1), 16'(k));
        @(posedge clock);
    endtask
    // Either write lane may carry a byte, a miss gives unknown
    task automatic cw(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] g;
        g = (ra.we === 1'b1 && ra.addr === a) ? ra.data :
            (rb.we === 1'b1 && rb.addr === a) ? rb.data : 8'hxx;
        chk("reg write", {8'h00, d}, {8'h00, g});
    endtask
    task automatic cf(input logic c, input logic z, input logic s, input logic v);
        chk("flags", {10'h000, c, z, s, v, pf.d, pf.h}, {10'h000, fl});
    endtask
    task automatic t_store;
        go('{opcode: OP_STORE_PREDEC, src_val: 8'h77, pair_val: 16'h3000, pair_addr: 8'h06,
            default: '0}, 14);
        chk("mem addr", 16'h2FFF, mw.addr);
        chk("to data", 16'h0000, {15'h0, mw.to_data});
        chk("prog", 16'h0077, {8'h00, mem.prog[16'h2FFF]});
        cw(8'h06, 8'h2F);
        cw(8'h07, 8'hFF);
        go('{opcode: OP_STORE_PREINC, src_val: 8'h7F, pair_val: 16'hFFFF, pair_addr: 8'h07,
            default: '0}, 14);
        chk("to data", 16'h0001, {15'h0, mw.to_data});
        chk("data", 16'h007F, {8'h00, mem.data[16'h0000]});
        cf(pf.c, pf.z, pf.s, pf.v);
    endtask
    task automatic t_word;
        for (int j = 0; j < 3; j++) begin
            go('{opcode: OP_WORD_RR + 8'(j), dst_addr: 8'h06, src_word: 16'h1234 + 16'(j),
                default: '0}, 8);
            cw(8'h06, 8'h12);
            cw(8'h07, 8'h34 + 8'(j));
        end
    endtask
    task automatic t_mul;
        logic [7:0] a [3] = '{8'h20, 8'h00, 8'hFF};
        logic [7:0] b [3] = '{8'h09, 8'h30, 8'hFF};
        logic [15:0] p;
        for (int j = 0; j < 3; j++) begin
            p = a[j] * b[j];
            go('{opcode: OP_MUL_R + 8'(j), dst_val: a[j], src_val: b[j], default: '0}, 22);
            cw(8'h00, p[15:8]);
            cw(8'h01, p[7:0]);
            cf(p > 16'h00FF, p == 16'h0000, p[15], 1'b0);
        end
    endtask
    task automatic t_or;
        logic [7:0] a [5] = '{8'h15, 8'h80, 8'h00, 8'h0F, 8'h08};
        logic [7:0] b [5] = '{8'h2A, 8'h01, 8'h00, 8'hF0, 8'h37};
        logic [7:0] r;
        for (int j = 0; j < 5; j++) begin
            r = a[j] | b[j];
            go('{opcode: OP_OR_LO + 8'(j), dst_addr: 8'h10, dst_val: a[j], src_val: b[j],
                default: '0}, j ? 6 : 4);
            cw(8'h10, r);
            cf(pf.c, r == 8'h00, r[7], 1'b0);
        end
    endtask
    task automatic t_next;
        mem.prog[0] = 8'h12;
        mem.prog[1] = 8'h34;
        mem.prog[2] = 8'hAB;
        mem.prog[3] = 8'hCD;
        for (int j = 0; j < 2; j++) begin
            go('{opcode: OP_NEXT, default: '0}, 10);
            chk("pc", j ? 16'hABCD : 16'h1234, pc);
            chk("ip", 16'(2 * j + 2), ip);
        end
        go('{opcode: OP_NOP, default: '0}, 4);
        chk("writes", 16'h0000, {13'h0, ra.we, rb.we, mw.we});
        chk("pc", 16'hABCD, pc);
    endtask
    task automatic t_stack;
        go('{opcode: OP_PUSH_R, src_val: 8'h55, default: '0}, 8);
        chk("sp", 16'hFFFF, sp);
        chk("push addr", 16'hFFFF, mw.addr);
        chk("push to data", 16'h0001, {15'h0, mw.to_data});
        chk("push data", 16'h0055, {8'h00, mw.data});
        go('{opcode: OP_POP_R, dst_addr: 8'h40, default: '0}, 8);
        cw(8'h40, 8'h55);
        chk("sp", 16'h0000, sp);
        go('{opcode: OP_UPOP_DEC, dst_val: 8'h42, src_val: 8'h02, src_word: 16'h006F,
            default: '0}, 8);
        cw(8'h02, 8'h6F);
        cw(8'h00, 8'h41);
        chk("mem we", 16'h0000, {15'h0, mw.we});
        go('{opcode: OP_UPOP_INC, dst_val: 8'h01, src_val: 8'h02, src_word: 16'h0070,
            default: '0}, 8);
        cw(8'h02, 8'h70);
        cw(8'h00, 8'h02);
        cf(pf.c, pf.z, pf.s, pf.v);
    endtask
    // Unknown opcode pulses illegal while start stands and never goes busy
    task automatic t_illegal;
        @(posedge clock);
        start <= 1'b1;
        instr <= '{opcode: 8'h01, default: '0};
        #1;
        chk("illegal", 16'h0001, {15'h0, illegal});
        @(posedge clock);
        start <= 1'b0;
        #1;
        chk("busy", 16'h0000, {15'h0, busy});
        chk("illegal low", 16'h0000, {15'h0, illegal});
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_next();
        t_store();
        t_word();
        t_mul();
        t_or();
        t_stack();
        t_illegal();
        end_of_test();
    end
endmodule
`default_nettype wire
